// file: inc/vcd_pkg.sv
/*
  vcd_pkg: constants and carrier types for the write-only two-wire current-sink slave.
  Assumes a 50 MHz system clock and a bus master that makes the serial clock.
*/
package vcd_pkg;
  // ------------------------------------------------------------
  // register and address constants
  // ------------------------------------------------------------
  localparam logic [7:0] VCD_CODE_RESET = 8'h00; // code after power-up or fault
  localparam logic [7:0] VCD_CODE_OFF = 8'h00; // code that turns the sink off
  localparam logic [5:0] VCD_ADDR_BASE = 6'h06; // byte bits 7..2 of 0x18, 0001_10
  localparam int VCD_STEP_UA = 500; // sink current per code step, microamps
  localparam int VCD_CUR_W = 17; // width of the target current in microamps
  localparam int VCD_ADDR_POS = 1; // address field starts above the direction bit
  localparam logic VCD_DIR_WRITE = 1'b0; // direction bit value for a write
  localparam logic [3:0] VCD_BITS_BYTE = 4'h8; // bits of a byte before acknowledge

  // ------------------------------------------------------------
  // transfer sequence states, gray along the usual path
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    VCD_IDLE = 2'b00, // waiting for a start
    VCD_ADDR = 2'b01, // shifting the address byte
    VCD_DATA = 2'b11, // shifting data bytes
    VCD_SKIP = 2'b10  // not selected, ignore until start
  } vcd_state_t;

  // sampled bus lines after synchronisers
  typedef struct packed {
    logic scl; // serial clock level
    logic sda; // serial data level
  } vcd_bus_t;

  // whole state of the slave
  typedef struct packed {
    vcd_bus_t s1; // first synchroniser stage
    vcd_bus_t s2; // second synchroniser stage
    vcd_bus_t pv; // previous synchronised level
    logic slp1; // sleep input first stage
    logic slp2; // sleep input second stage
    vcd_state_t st; // transfer sequence state
    logic [3:0] bits; // bits shifted in this byte
    logic [7:0] sh; // shift register
    logic ack; // acknowledge window active
    logic ack_ok; // acknowledge is driven in this window
    logic [7:0] code; // sink current code
  } vcd_regs_t;
endpackage : vcd_pkg

// file: rtl/vcd_slave.sv
/*
  vcd_slave: two-wire write-only slave holding the sink current code.
  Assumes the master owns the serial clock, lines are pulled up outside, and the
  50 MHz clock oversamples the serial clock (bench period 160 ns).
*/
// Function
// - target current is code times 500 uA
// - code zero disables sink drive
// - code clears at power-up or supply fault
// - sleep low disables sink drive and serial logic, code kept
// - detect start: data falls, clock high
// - detect stop: data rises, clock high
// - first byte: address, direction, acknowledge
// - recognise 0x18, 0x1A, 0x1C, 0x1E
// - data bytes msb first into register
// - start or stop resets transfer sequence
// - write only, no read-back path
// - several data bytes per transfer accepted
// - acknowledge matching address in ninth clock
// - acknowledge every data byte
// - master clocks; device only pulls low
`timescale 1ns/100ps
module vcd_slave (
  input wire logic i_ref_clk, // 50 MHz system clock
  input wire logic i_rst, // synchronous reset, high
  input wire logic i_supply_fault, // supply fault, same clock domain
  input wire logic [1:0] i_addr_sel, // address setting, selects 0x18..0x1E
  input wire logic i_scl, // serial clock pin
  input wire logic i_sda, // serial data pin, input side
  output logic o_sda, // serial data pin, output value
  output logic o_sda_oe, // serial data pin, drive enable
  input wire logic i_sleep_low_input_n, // sleep input, active low
  output logic [7:0] o_sink_current_code, // stored code
  output logic [vcd_pkg::VCD_CUR_W-1:0] o_current_sink_pin_ua, // target current, uA
  output logic o_current_sink_pin_en // sink drive enable
);
  import vcd_pkg::*;

  // ------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------
  vcd_regs_t r_q; // registered state
  vcd_regs_t r_d; // next state
  logic start_det; // start condition seen
  logic stop_det; // stop condition seen
  logic scl_rise; // serial clock rising edge
  logic scl_fall; // serial clock falling edge
  logic awake; // sleep input released

  // address match; address setting picks bits two and one of the byte
  function automatic logic vcd_addr_hit(input logic [7:0] b, input logic [1:0] sel);
    vcd_addr_hit = (b[7:2] == VCD_ADDR_BASE) && (b[1] == sel[0]) && (sel[1] == 1'b0)
                   || (b[7:2] == VCD_ADDR_BASE + 6'h01) && (b[1] == sel[0]) && sel[1];
  endfunction : vcd_addr_hit

  // ------------------------------------------------------------
  // edge detection on synchronised lines
  // ------------------------------------------------------------
  // only second stage and its delayed copy are looked at
  always_comb begin
    start_det = r_q.pv.sda && !r_q.s2.sda && r_q.s2.scl && r_q.pv.scl;
    stop_det = !r_q.pv.sda && r_q.s2.sda && r_q.s2.scl && r_q.pv.scl;
    scl_rise = !r_q.pv.scl && r_q.s2.scl;
    scl_fall = r_q.pv.scl && !r_q.s2.scl;
    awake = r_q.slp2;
  end

  // ------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.s1 = '{scl: i_scl, sda: i_sda};
    r_d.s2 = r_q.s1;
    r_d.pv = r_q.s2;
    r_d.slp1 = i_sleep_low_input_n;
    r_d.slp2 = r_q.slp1;
    if (!awake) begin
      // sleeping: serial logic held idle, code kept
      r_d.st = VCD_IDLE;
      r_d.bits = 4'h0;
      r_d.ack = 1'b0;
      r_d.ack_ok = 1'b0;
    end else if (start_det) begin
      // any start abandons the byte and begins an address
      r_d.st = VCD_ADDR;
      r_d.bits = 4'h0;
      r_d.ack = 1'b0;
      r_d.ack_ok = 1'b0;
    end else if (stop_det) begin
      r_d.st = VCD_IDLE;
      r_d.bits = 4'h0;
      r_d.ack = 1'b0;
      r_d.ack_ok = 1'b0;
    end else begin
      unique case (r_q.st)
        VCD_IDLE, VCD_SKIP: begin
          // ignoring the bus until the next start
          r_d.ack = 1'b0;
        end
        VCD_ADDR, VCD_DATA: begin
          if (r_q.ack) begin
            // acknowledge held through the ninth clock high, ends at its fall
            if (scl_fall) begin
              r_d.ack = 1'b0;
              r_d.ack_ok = 1'b0;
              r_d.bits = 4'h0;
            end
          end else begin
            if (scl_rise) begin
              // sample data on clock high, msb first
              r_d.sh = {r_q.sh[6:0], r_q.s2.sda};
              r_d.bits = r_q.bits + 4'h1;
            end
            if (scl_fall && r_q.bits == VCD_BITS_BYTE) begin
              // eighth bit done: decide acknowledge for the ninth clock
              r_d.ack = 1'b1;
              if (r_q.st == VCD_ADDR) begin
                // read direction is never acknowledged: no read-back
                if (vcd_addr_hit(r_q.sh, i_addr_sel)
                    && r_q.sh[0] == VCD_DIR_WRITE) begin
                  r_d.ack_ok = 1'b1;
                  r_d.st = VCD_DATA;
                end else begin
                  r_d.ack = 1'b0;
                  r_d.st = VCD_SKIP;
                end
              end else begin
                r_d.code = r_q.sh;
                r_d.ack_ok = 1'b1;
              end
            end
          end
        end
      endcase
    end
    // supply fault or reset clears the code
    if (i_supply_fault) begin
      r_d.code = VCD_CODE_RESET;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      r_q <= '{s1: '{scl: 1'b1, sda: 1'b1}, s2: '{scl: 1'b1, sda: 1'b1},
               pv: '{scl: 1'b1, sda: 1'b1}, slp1: 1'b0, slp2: 1'b0, st: VCD_IDLE,
               bits: 4'h0, sh: 8'h00, ack: 1'b0, ack_ok: 1'b0,
               code: VCD_CODE_RESET};
    end else begin
      r_q <= r_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // open drain: only ever drive low, never high
  always_comb begin
    o_sda = 1'b0;
    o_sda_oe = r_q.ack && r_q.ack_ok && awake;
    o_sink_current_code = r_q.code;
    o_current_sink_pin_en = awake && (r_q.code != VCD_CODE_OFF);
    o_current_sink_pin_ua = o_current_sink_pin_en ?
      VCD_CUR_W'(r_q.code * VCD_STEP_UA) : '0;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  sequence s_byte_end;
    awake && !start_det && !stop_det && !r_q.ack && scl_fall && r_q.bits == 4'h8;
  endsequence

  a_sink_current: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_current_sink_pin_en |-> o_current_sink_pin_ua == VCD_CUR_W'(r_q.code * 500))
    else $error("sink current not code times step");
  a_zero_off: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    r_q.code == 8'h00 |-> !o_current_sink_pin_en)
    else $error("sink enabled at code zero");
  a_fault_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_supply_fault |=> o_sink_current_code == 8'h00)
    else $error("fault did not clear code");
  a_sleep_off: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !r_q.slp2 |-> !o_current_sink_pin_en && !o_sda_oe)
    else $error("activity while asleep");
  a_start_seq: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    awake && start_det |=> r_q.st == VCD_ADDR && r_q.bits == 4'h0)
    else $error("start not detected");
  a_stop_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    awake && stop_det && !start_det |=> r_q.st == VCD_IDLE && !o_sda_oe)
    else $error("stop not detected");
  a_data_store: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_byte_end and (r_q.st == VCD_DATA) and !i_supply_fault
    |=> o_sink_current_code == $past(r_q.sh) && o_sda_oe)
    else $error("data byte not stored or acknowledged");
  a_addr_ack: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_byte_end and (r_q.st == VCD_ADDR) and (vcd_addr_hit(r_q.sh, i_addr_sel))
    and (r_q.sh[0] == 1'b0) |=> o_sda_oe && r_q.st == VCD_DATA)
    else $error("matching address not acknowledged");
  a_miss_skip: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    r_q.st == VCD_SKIP |-> !o_sda_oe)
    else $error("driving while not selected");

  // ------------------------------------------------------------
  // further checks on the serial sequence
  // ------------------------------------------------------------
  // frame as seen on the synchronised copies, one byte:
  //   eight clock rises, each shifts one bit in at the bottom
  //   eighth fall opens the acknowledge slot for the ninth clock
  //   ninth fall closes the slot and clears the bit count
  // the slot opens and closes about three reference clocks late,
  // which is why the serial clock must stay low a few clocks;
  // a faster master would see the pull-down too late or too long
  // start or stop anywhere drops the partial byte

  // a bit is taken: awake, no condition, clock rises outside the slot
  sequence s_bit_take;
    awake && !start_det && !stop_det && !r_q.ack && scl_rise
      && (r_q.st == VCD_ADDR || r_q.st == VCD_DATA);
  endsequence

  // the ninth clock ends: falling edge while the slot is open
  sequence s_ack_end;
    awake && !start_det && !stop_det && r_q.ack && scl_fall;
  endsequence

  // bits enter at the bottom, so the first one ends up as the msb
  a_msb_first: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_bit_take |=> r_q.sh == {$past(r_q.sh[6:0]), $past(r_q.s2.sda)})
    else $error("data bit not shifted in msb first");

  // the counter never runs past a whole byte
  a_bits_bound: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    r_q.bits <= VCD_BITS_BYTE)
    else $error("bit count beyond one byte");

  // the pull-down is let go after the ninth clock
  a_ack_ends: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_ack_end |=> !o_sda_oe && r_q.bits == 4'h0)
    else $error("acknowledge not released after ninth clock");

  // the pull-down stands until the ninth clock falls
  a_ack_stands: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_sda_oe && r_q.slp1 && !scl_fall && !start_det && !stop_det |=> o_sda_oe)
    else $error("acknowledge dropped early");

  // a read request is never answered: nothing to read back
  a_read_refused: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_byte_end and (r_q.st == VCD_ADDR) and (r_q.sh[0] != VCD_DIR_WRITE)
    |=> !o_sda_oe && r_q.st == VCD_SKIP)
    else $error("read direction acknowledged");

  // a foreign address is never answered
  a_addr_refused: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_byte_end and (r_q.st == VCD_ADDR) and (!vcd_addr_hit(r_q.sh, i_addr_sel))
    |=> !o_sda_oe && r_q.st == VCD_SKIP)
    else $error("foreign address acknowledged");

  // once deselected, only a start brings the sequence back
  a_skip_stays: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    r_q.st == VCD_SKIP && !start_det |=> r_q.st != VCD_ADDR && r_q.st != VCD_DATA)
    else $error("left ignore state without start");

  // asleep: sequence idle and no pull-down
  a_sleep_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !awake |=> r_q.st == VCD_IDLE && !o_sda_oe)
    else $error("serial logic active while asleep");

  // asleep: the code is kept for the wake-up
  a_sleep_keeps: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !awake && !i_supply_fault |=> $stable(o_sink_current_code))
    else $error("code changed while asleep");

  // asleep: target current forced to zero
  a_sleep_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !awake |-> o_current_sink_pin_ua == '0)
    else $error("target current while asleep");

  // the data pin value is only ever low
  a_open_drain: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_sda == 1'b0)
    else $error("data pin driven high");

  // awake with a nonzero code the sink is on
  a_sink_on: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    awake && r_q.code != VCD_CODE_OFF |-> o_current_sink_pin_en)
    else $error("sink off with nonzero code");

  // no data before an address: idle never touches the code
  a_idle_keeps: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    r_q.st == VCD_IDLE && !i_supply_fault |=> $stable(o_sink_current_code))
    else $error("code changed without address");

  // inside a data byte the code moves only at its end
  a_code_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    r_q.st == VCD_DATA && !i_supply_fault
    && !(scl_fall && !r_q.ack && r_q.bits == VCD_BITS_BYTE)
    |=> $stable(o_sink_current_code))
    else $error("code changed mid byte");

  // a stop drops any partial byte and the pull-down
  a_stop_drops: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    awake && stop_det && !start_det |=> r_q.bits == 4'h0 && !r_q.ack)
    else $error("partial byte kept over stop");
endmodule : vcd_slave

// file: testbench/vcd_master_model.sv
/*
  vcd_master_model: behavioural two-wire bus master that writes the current-sink slave.
  Assumes an open-drain data line with a pull-up built outside; clock idles high.
*/
`timescale 1ns/100ps
module vcd_master_model (
  input wire logic i_sda, // data line level on the wire
  output logic o_scl, // serial clock, still and high between frames
  output logic o_sda_low // pulls the data line low while set
);
  // ------------------------------------------------------------
  // idle bus: both lines released
  // ------------------------------------------------------------
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end

  // start or repeated start: data falls while clock high
  task start;
    o_sda_low = 1'b0;
    #40 o_scl = 1'b1;
    #80 o_sda_low = 1'b1;
    #80 o_scl = 1'b0;
    #40;
  endtask : start

  // stop: data rises while clock high
  task stop;
    o_sda_low = 1'b1;
    #40 o_scl = 1'b1;
    #80 o_sda_low = 1'b0;
    #80;
  endtask : stop

  // n bits msb first; a whole byte also gets the acknowledge clock
  task send(input logic [7:0] b, input int n, output logic ack);
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      o_sda_low = ~b[i];
      #40 o_scl = 1'b1;
      #80 o_scl = 1'b0;
      #40;
    end
    if (n == 8) begin
      o_sda_low = 1'b0;
      #40 o_scl = 1'b1;
      #40 ack = ~i_sda;
      #40 o_scl = 1'b0;
      #40;
    end
  endtask : send
endmodule : vcd_master_model

// file: testbench/vcd_slave_tb.sv
/*
  vcd_slave_tb: self-checking bench for the current-sink slave.
  Assumes the behavioural master model drives the serial lines.
*/
`timescale 1ns/100ps
module vcd_slave_tb;
  import vcd_pkg::*;
  logic clk = 1'b0; // 50 MHz reference
  logic rst = 1'b1; // synchronous reset
  logic fault = 1'b0; // supply fault
  logic slp_n = 1'b1; // sleep, active low
  logic [1:0] sel = 2'h0; // address setting
  logic sda_oe, sda_o, en; // slave outputs
  logic [7:0] code; // stored code
  logic [VCD_CUR_W-1:0] ua; // target current
  wire scl, m_low; // master lines
  wire sda = ~(m_low | sda_oe); // wired-and with pull-up
  int fails = 0;
  int n_compared = 0;

  vcd_slave vcd_slave_inst (.i_ref_clk(clk), .i_rst(rst), .i_supply_fault(fault),
    .i_addr_sel(sel), .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe),
    .i_sleep_low_input_n(slp_n), .o_sink_current_code(code),
    .o_current_sink_pin_ua(ua), .o_current_sink_pin_en(en));
  vcd_master_model vcd_master_model_inst (.i_sda(sda), .o_scl(scl), .o_sda_low(m_low));

  initial forever #10 clk = ~clk;

  // ------------------------------------------------------------
  // compare, verdict and helpers
  // ------------------------------------------------------------
  task chk(input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task print_verdict;
    if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task cyc(input int n); // inputs change 1 ns after the edge
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // settled outputs: code, current and enable
  task outs(input logic [7:0] c, input logic e);
    cyc(4);
    chk(code, c);
    chk(ua, e ? 17'(c * VCD_STEP_UA) : 17'h0);
    chk(en, e);
    chk(sda_o, 1'b0);
  endtask : outs
  // addressed write of nd bytes, alternating d and ~d
  task wr(input logic [7:0] a, input logic [7:0] d, input int nd, input logic ak);
    logic k;
    vcd_master_model_inst.start();
    vcd_master_model_inst.send(a, 8, k);
    chk(k, ak);
    repeat (nd) begin
      vcd_master_model_inst.send(d, 8, k);
      chk(k, ak);
      if (ak) chk(code, d);
      d = ~d;
    end
    vcd_master_model_inst.stop();
  endtask : wr

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic k;
    cyc(20);
    rst = 1'b0;
    cyc(6);
    outs(8'h00, 1'b0);
    for (int s = 0; s < 4; s++) begin
      sel = s[1:0];
      wr(8'h18 + 8'(2 * s), 8'h81 + 8'(s), 1, 1'b1);
      outs(8'h81 + 8'(s), 1'b1);
      wr(8'h18 + 8'(2 * ((s + 1) % 4)), 8'h55, 1, 1'b0);
      outs(8'h81 + 8'(s), 1'b1);
    end
    wr(8'h1F, 8'h33, 1, 1'b0);
    outs(8'h84, 1'b1);
    wr(8'h1E, 8'hFF, 2, 1'b1);
    outs(8'h00, 1'b0);
    wr(8'h1E, 8'h00, 2, 1'b1);
    outs(8'hFF, 1'b1);
    vcd_master_model_inst.start();
    vcd_master_model_inst.send(8'h1E, 8, k);
    vcd_master_model_inst.send(8'h12, 4, k);
    vcd_master_model_inst.stop();
    outs(8'hFF, 1'b1);
    vcd_master_model_inst.start();
    vcd_master_model_inst.send(8'h1E, 8, k);
    vcd_master_model_inst.send(8'h12, 5, k);
    wr(8'h1E, 8'h3C, 1, 1'b1);
    fault = 1'b1;
    cyc(1);
    fault = 1'b0;
    outs(8'h00, 1'b0);
    wr(8'h1E, 8'h40, 1, 1'b1);
    slp_n = 1'b0;
    outs(8'h40, 1'b0);
    wr(8'h1E, 8'h22, 1, 1'b0);
    slp_n = 1'b1;
    outs(8'h40, 1'b1);
    print_verdict();
  end

  // hang guard, far beyond the roughly 56 us of traffic
  initial begin
    #500000;
    fails++;
    print_verdict();
  end
endmodule : vcd_slave_tb
